/* src/psc_ctrl.v */
// Controller driving the memory pins for sleep, deep sleep and configuration loads.
// Assumes an AHB-Lite master and a memory on the same board; data bus is a split three-signal pin.
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "psc_map.vh"
// Overview of operation
// (RULE_01) Memory idles when chip select and sleep pin are both high.
// (RULE_02) Memory drops power after static inputs; controller keeps pins static when idle.
// (RULE_03) Software picks a temperature threshold above case temperature in bits 6 to 5.
// (RULE_04) Subset mode refreshes full array or none.
// (RULE_05) Memory ignores accesses in subset mode; controller issues none after pin entry, but still can after a software-write entry.
// (RULE_06) Subset mode needs bit 4 set and sleep pin low over 10 us.
// (RULE_07) Raising sleep pin leaves subset mode at once.
// (RULE_08) Software sequence setting bit 4 enables subset mode at once.
// (RULE_09) After a software write, sleep low no longer starts subset mode; the controller still sets asleep_r whatever sw_written_r is.
// (RULE_10) Deep sleep stops refresh and ignores accesses.
// (RULE_11) Deep sleep needs bit 4 clear and sleep pin low over 10 us.
// (RULE_12) After deep sleep exit the controller waits 150 us before operations.
// (RULE_13) Deep sleep is entered and left only through the sleep pin.
// (RULE_14) Memory powers up with configuration 0070h.
// (RULE_15) Configuration is only loaded from a standby state.
// (RULE_16) Pin load writes address 19 to 0 right after sleep pin falls.
// (RULE_17) Pin load path is write only.
// (RULE_18) Software write is two reads, two writes; read ends with a read.
// (RULE_19) All four software operations use the highest address.
// (RULE_20) Configuration bits 15 to 0 travel on the data bus.
// (RULE_21) Memory re-evaluates subset mode on each software load.
// (RULE_22) Bits 6 to 5 select the refresh temperature.
// (RULE_23) Bit 7 enables page-mode reads.
// (RULE_24) Bits 2 to 0 select full or no array refresh.
// (RULE_25) Sleep pulses of 10 us or less commit to no low-power mode.
module psc_ctrl #(
    parameter SLEEP_CYC = `PSC_SLEEP_CYC,
    parameter INIT_CYC = `PSC_INIT_CYC
) (
    input wire clk,
    input wire reset,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    output reg chip_select_n,
    output reg write_strobe_n,
    output reg output_enable_n,
    output reg [1:0] byte_lane_selects,
    output reg [19:0] mem_addr,
    output reg [15:0] mem_dq_out,
    output reg mem_dq_oe,
    input wire [15:0] mem_dq_in,
    output reg sleep_enable_n
);
    localparam ST_IDLE = 4'h0;
    localparam ST_PIN_FALL = 4'h1;
    localparam ST_OP_SET = 4'h2;
    localparam ST_OP_STROBE = 4'h3;
    localparam ST_OP_END = 4'h4;
    localparam ST_PIN_RISE = 4'h5;
    localparam ST_SLEEP = 4'h6;
    localparam ST_INIT = 4'h7;
    localparam ST_GAP = 4'h8;
    wire [2:0] cmd;
    wire cmd_go;
    wire [19:0] cfg;
    reg [3:0] state_r;
    reg [1:0] op_idx_r;
    reg pin_load_r;
    reg rd_last_r;
    reg asleep_r;
    reg deep_r;
    reg sw_written_r;
    reg busy_r;
    reg [15:0] rd_data_r;
    reg [31:0] cnt_r;
    reg [15:0] dq_s1_r, dq_s2_r, dq_s3_r;
    reg [15:0] dq_filt_r;
    wire [7:0] status;
    assign status = {3'h0, sw_written_r, deep_r, asleep_r, state_r == ST_INIT, busy_r};
    psc_ahb_regs u_regs (
        .clk(clk),
        .reset(reset),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .status(status),
        .rd_data(rd_data_r),
        .cmd_r(cmd),
        .cmd_go_r(cmd_go),
        .cfg_r(cfg)
    );
    // Returns true on a pin load, or when the operation index selects a write strobe.
    function op_is_write;
        input [1:0] idx;
        input pin_load;
        input rd_last;
        begin
            op_is_write = pin_load || (idx == 2'd2) || (idx == 2'd3 && !rd_last);
        end
    endfunction
    // Input sampler for data pins, compared on second and third stage.
    always @(posedge clk) begin
        if (reset) begin
            dq_s1_r <= 16'h0000;
            dq_s2_r <= 16'h0000;
            dq_s3_r <= 16'h0000;
            dq_filt_r <= 16'h0000;
        end else begin
            dq_s1_r <= mem_dq_in;
            dq_s2_r <= dq_s1_r;
            dq_s3_r <= dq_s2_r;
            if (dq_s2_r == dq_s3_r) begin
                dq_filt_r <= dq_s3_r;
            end
        end
    end
    always @(posedge clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            op_idx_r <= 2'd0;
            pin_load_r <= 1'b0;
            rd_last_r <= 1'b0;
            asleep_r <= 1'b0;
            deep_r <= 1'b0;
            sw_written_r <= 1'b0;
            busy_r <= 1'b0;
            rd_data_r <= 16'h0000;
            cnt_r <= 32'h00000000;
            chip_select_n <= 1'b1;
            write_strobe_n <= 1'b1;
            output_enable_n <= 1'b1;
            byte_lane_selects <= 2'h3;
            mem_addr <= 20'h00000;
            mem_dq_out <= 16'h0000;
            mem_dq_oe <= 1'b0;
            sleep_enable_n <= 1'b1;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    busy_r <= 1'b0;
                    cnt_r <= 32'h00000000;
                    // (RULE_15) Loads start from standby only.
                    if (cmd_go && !asleep_r) begin
                        busy_r <= 1'b1;
                        op_idx_r <= 2'd0;
                        case (cmd)
                            `PSC_CMD_PIN_LOAD: begin
                                // (RULE_16) Sleep pin falls first.
                                pin_load_r <= 1'b1;
                                sleep_enable_n <= 1'b0;
                                state_r <= ST_PIN_FALL;
                            end
                            `PSC_CMD_SW_WRITE, `PSC_CMD_SW_READ: begin
                                // (RULE_18) Four-operation sequence.
                                pin_load_r <= 1'b0;
                                rd_last_r <= (cmd == `PSC_CMD_SW_READ);
                                state_r <= ST_OP_SET;
                            end
                            `PSC_CMD_SLEEP: begin
                                // (RULE_13) Low-power entry by pin.
                                sleep_enable_n <= 1'b0;
                                state_r <= ST_SLEEP;
                            end
                            default: busy_r <= 1'b0;
                        endcase
                    end else if (cmd_go && cmd == `PSC_CMD_WAKE && asleep_r) begin
                        // (RULE_07) Raising the pin ends low power.
                        sleep_enable_n <= 1'b1;
                        asleep_r <= 1'b0;
                        busy_r <= 1'b1;
                        state_r <= deep_r ? ST_INIT : ST_IDLE;
                    end
                end
                ST_PIN_FALL: begin
                    cnt_r <= cnt_r + 32'd1;
                    if (cnt_r == `PSC_PULSE_CYC) begin
                        state_r <= ST_OP_SET;
                    end
                end
                ST_OP_SET: begin
                    // (RULE_19) Top address, or configuration on pin load.
                    mem_addr <= pin_load_r ? cfg : `PSC_TOP_ADDR;
                    chip_select_n <= 1'b0;
                    byte_lane_selects <= 2'h0;
                    cnt_r <= 32'h00000000;
                    if (op_is_write(op_idx_r, pin_load_r, rd_last_r)) begin
                        // (RULE_20) Data bus carries bits 15 to 0.
                        mem_dq_out <= cfg[15:0];
                        mem_dq_oe <= !pin_load_r;
                        write_strobe_n <= 1'b0;
                    end else begin
                        output_enable_n <= 1'b0;
                    end
                    state_r <= ST_OP_STROBE;
                end
                ST_OP_STROBE: begin
                    cnt_r <= cnt_r + 32'd1;
                    if (cnt_r == `PSC_PULSE_CYC) begin
                        if (op_idx_r == 2'd3 && rd_last_r) begin
                            rd_data_r <= dq_filt_r;
                        end
                        // (RULE_16) Write strobe rises before chip select.
                        write_strobe_n <= 1'b1;
                        output_enable_n <= 1'b1;
                        state_r <= ST_OP_END;
                    end
                end
                ST_OP_END: begin
                    chip_select_n <= 1'b1;
                    byte_lane_selects <= 2'h3;
                    mem_dq_oe <= 1'b0;
                    if (pin_load_r) begin
                        state_r <= ST_PIN_RISE;
                    end else if (op_idx_r == 2'd3) begin
                        // (RULE_09) Software write changes pin behaviour.
                        if (!rd_last_r) begin
                            sw_written_r <= 1'b1;
                        end
                        state_r <= ST_GAP;
                    end else begin
                        op_idx_r <= op_idx_r + 2'd1;
                        state_r <= ST_OP_SET;
                    end
                end
                ST_PIN_RISE: begin
                    // (RULE_25) Short sleep pulse commits to nothing.
                    sleep_enable_n <= 1'b1;
                    state_r <= ST_GAP;
                end
                ST_SLEEP: begin
                    // (RULE_06) Hold low beyond 10 us before committing.
                    // (RULE_11) Mode follows configuration bit 4.
                    cnt_r <= cnt_r + 32'd1;
                    if (cnt_r == SLEEP_CYC) begin
                        asleep_r <= 1'b1;
                        deep_r <= !cfg[`PSC_CR_SLEEP_BIT];
                        busy_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
                ST_INIT: begin
                    // (RULE_12) Wait out the initialisation.
                    cnt_r <= cnt_r + 32'd1;
                    if (cnt_r == INIT_CYC) begin
                        deep_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
                ST_GAP: begin
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule // psc_ctrl
`default_nettype wire

/* pkg/psc_map.vh */
// Constants for the pseudo-static memory low-power and configuration controller.
// Assumes inclusion by bare name from the design files of this block.
`ifndef PSC_MAP_VH
`define PSC_MAP_VH
`define PSC_CLK_MHZ 20
`define PSC_SLEEP_MIN_US 10
`define PSC_SLEEP_CYC ((`PSC_SLEEP_MIN_US * `PSC_CLK_MHZ) + 1)
`define PSC_INIT_US 150
`define PSC_INIT_CYC (`PSC_INIT_US * `PSC_CLK_MHZ)
`define PSC_PULSE_CYC 4
`define PSC_TOP_ADDR 20'hfffff
`define PSC_CR_RESET 20'h00070
`define PSC_CR_SLEEP_BIT 4
`define PSC_REG_CTRL 4'h0
`define PSC_REG_CFG 4'h4
`define PSC_REG_STATUS 4'h8
`define PSC_REG_RDDATA 4'hc
`define PSC_CMD_NONE 3'h0
`define PSC_CMD_PIN_LOAD 3'h1
`define PSC_CMD_SW_WRITE 3'h2
`define PSC_CMD_SW_READ 3'h3
`define PSC_CMD_SLEEP 3'h4
`define PSC_CMD_WAKE 3'h5
`endif

/* src/psc_ahb_regs.v */
// AHB-Lite slave holding the controller command, configuration and status words.
// Assumes a single master, word transfers, and zero-wait answers.
`timescale 1ns/10ps
`default_nettype none
`include "psc_map.vh"
module psc_ahb_regs (
    input wire clk,
    input wire reset,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire [7:0] status,
    input wire [15:0] rd_data,
    output reg [2:0] cmd_r,
    output reg cmd_go_r,
    output reg [19:0] cfg_r
);
    reg wr_pend_r;
    reg [3:0] wr_addr_r;
    wire take;
    wire mapped;
    assign take = hsel && htrans[1];
    assign mapped = (haddr[31:4] == 28'h0000000);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    always @(posedge clk) begin
        if (reset) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 4'h0;
            cmd_r <= `PSC_CMD_NONE;
            cmd_go_r <= 1'b0;
            cfg_r <= `PSC_CR_RESET;
            hrdata <= 32'h00000000;
        end else begin
            cmd_go_r <= 1'b0;
            wr_pend_r <= take && hwrite && mapped;
            wr_addr_r <= haddr[3:0];
            if (take && !hwrite && !mapped) begin
                hrdata <= 32'h00000000;
            end
            if (take && !hwrite && mapped) begin
                case (haddr[3:0])
                    `PSC_REG_CTRL: hrdata <= {29'h0, cmd_r};
                    `PSC_REG_CFG: hrdata <= {12'h0, cfg_r};
                    `PSC_REG_STATUS: hrdata <= {24'h0, status};
                    `PSC_REG_RDDATA: hrdata <= {16'h0, rd_data};
                    default: hrdata <= 32'h00000000;
                endcase
            end
            if (wr_pend_r) begin
                case (wr_addr_r)
                    `PSC_REG_CTRL: begin
                        cmd_r <= hwdata[2:0];
                        cmd_go_r <= 1'b1;
                    end
                    // (RULE_03) Software sets threshold.
                    `PSC_REG_CFG: cfg_r <= hwdata[19:0];
                    default: cmd_go_r <= 1'b0;
                endcase
            end
        end
    end
endmodule // psc_ahb_regs
`default_nettype wire

/* bench/psc_mem_model.sv */
// Behavioural memory device: configuration register, sleep pin modes and software access sequence.
// Assumes direct connection to the controller pins; times are scaled to the shortened controller counts.
`timescale 1ns/10ps
`default_nettype none
module psc_mem_model #(
    parameter real LOW_NS = 400.0,
    parameter real INIT_NS = 800.0
) (
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic [19:0] mem_addr,
    input wire logic [15:0] mem_dq_out,
    input wire logic sleep_enable_n,
    output logic [15:0] mem_dq_in
);
    logic [19:0] cr = 20'h00070;
    logic [15:0] wd = 16'h0;
    int mode = 0, s = 0, early = 0;
    bit sw_done = 0, armed = 0, wr = 0, used = 0;
    realtime woke = -1.0e6;
    // sequence read drives the register, otherwise the inverse.
    assign mem_dq_in = (!chip_select_n && !output_enable_n && s == 3) ? cr[15:0] : ~cr[15:0];
    // long quiet low enters a mode.
    always @(negedge sleep_enable_n) begin
        used = 0;
        #(LOW_NS);
        if (!sleep_enable_n && !used) mode = cr[4] ? (sw_done ? 0 : 1) : 2;
    end
    always @(posedge sleep_enable_n) begin
        if (mode == 2) woke = $realtime;
        mode = 0;
    end
    always @(negedge chip_select_n) begin
        used = 1;
        armed = 1;
        if ($realtime - woke < INIT_NS) early++;
    end
    always @(negedge write_strobe_n) wr = 1;
    always @(posedge write_strobe_n or posedge chip_select_n) begin
        if (!chip_select_n) wd = mem_dq_out;
        if (armed && !sleep_enable_n) cr = mem_addr;
        else if (armed && mode == 0 && mem_addr == 20'hfffff) begin
            if (s == 3 && wr) cr[15:0] = wd;
            if (s == 3 && wr) sw_done = 1;
            if (s == 3 && wr && cr[4]) mode = 1;
            s = (s < 3 && wr == (s == 2)) ? s + 1 : 0;
        end
        armed = 0;
        wr = 0;
    end
endmodule // psc_mem_model
`default_nettype wire

/* bench/psc_ctrl_assertions.sv */
// Checker of the controller memory pins.
// Assumes it is bound to psc_ctrl.
`timescale 1ns/10ps
`default_nettype none
module psc_ctrl_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic [1:0] byte_lane_selects,
    input wire logic [19:0] mem_addr,
    input wire logic mem_dq_oe,
    input wire logic sleep_enable_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    a_idle_quiet: assert property (chip_select_n |-> write_strobe_n && output_enable_n)
        else $error("strobe outside select");
    a_top_address: assert property (!chip_select_n && sleep_enable_n |-> mem_addr == 20'hfffff)
        else $error("sequence address wrong");
    a_drive_write: assert property (mem_dq_oe |-> output_enable_n && sleep_enable_n)
        else $error("data driven wrongly");
    a_write_width: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*5] ##1 write_strobe_n)
        else $error("write width wrong");
    a_read_width: assert property ($fell(output_enable_n) |-> !output_enable_n [*5] ##1 output_enable_n)
        else $error("read width wrong");
    a_select_end: assert property ($rose(write_strobe_n) || $rose(output_enable_n) |-> !chip_select_n ##1 chip_select_n)
        else $error("select not released");
    a_load_early: assert property (!sleep_enable_n && $fell(chip_select_n) |-> $past(sleep_enable_n, 8))
        else $error("load write late");
    a_load_release: assert property (!sleep_enable_n && $rose(chip_select_n) |=> sleep_enable_n)
        else $error("sleep held after load");
    a_lane_follow: assert property (byte_lane_selects == {2{chip_select_n}})
        else $error("lanes wrong");
endmodule // psc_ctrl_checker
bind psc_ctrl psc_ctrl_checker i_psc_ctrl_checker (.clk(clk), .reset(reset), .chip_select_n(chip_select_n),
    .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n), .byte_lane_selects(byte_lane_selects),
    .mem_addr(mem_addr), .mem_dq_oe(mem_dq_oe), .sleep_enable_n(sleep_enable_n));
`default_nettype wire

/* bench/tb.sv */
// Testbench: AHB-Lite master driving the controller against the memory model.
// Assumes shortened sleep and initialisation counts.
`timescale 1ns/10ps
`default_nettype none
`include "psc_map.vh"
module tb;
    logic clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [1:0] htrans = 2'h0, byte_lane_selects;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, chip_select_n, write_strobe_n, output_enable_n, mem_dq_oe, sleep_enable_n;
    logic [19:0] mem_addr, v;
    logic [15:0] mem_dq_out, mem_dq_in;
    int miscompares = 0, samples_checked = 0, seed;
    psc_ctrl #(.SLEEP_CYC(8), .INIT_CYC(16)) i_psc_ctrl (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
        .output_enable_n(output_enable_n), .byte_lane_selects(byte_lane_selects), .mem_addr(mem_addr),
        .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in), .sleep_enable_n(sleep_enable_n));
    psc_mem_model i_psc_mem_model (.chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n),
        .output_enable_n(output_enable_n), .mem_addr(mem_addr), .mem_dq_out(mem_dq_out),
        .sleep_enable_n(sleep_enable_n), .mem_dq_in(mem_dq_in));
    initial forever #25 clk = ~clk;
    task report_and_stop;
        $display("compared %0d mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task rd(input logic [31:0] a);
        ahb(1'b0, a, $urandom);
    endtask
    task cmd(input logic [2:0] c);
        ahb(1'b1, `PSC_REG_CTRL, {29'h0, c});
        repeat (3) @(posedge clk);
        r = 32'h1;
        for (int n = 0; n < 400 && r[0] !== 1'b0; n++) rd(`PSC_REG_STATUS);
        chk("busy", 32'h0, {31'h0, r[0]});
    endtask
    initial begin
        #1000000;
        miscompares++;
        report_and_stop;
    end
    initial begin
        seed = $urandom(32'h4ce5);
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(`PSC_REG_CFG);
        chk("cfg", 32'h70, r);
        rd(`PSC_REG_STATUS);
        chk("status", 32'h0, r);
        chk("power-up", 32'h70, i_psc_mem_model.cr);
        for (int i = 0; i < 4; i++) begin
            v = 20'(i * 32 + (i % 2) * 16 + $urandom % 8);
            ahb(1'b1, `PSC_REG_CFG, {12'h0, v});
            cmd(`PSC_CMD_PIN_LOAD);
            chk("pin load", {12'h0, v}, i_psc_mem_model.cr);
            chk("mode", 0, i_psc_mem_model.mode);
            cmd(`PSC_CMD_SW_READ);
            rd(`PSC_REG_RDDATA);
            chk("sw read", {16'h0, v[15:0]}, r);
            cmd(`PSC_CMD_SLEEP);
            repeat (12) @(posedge clk);
            chk("low mode", v[4] ? 1 : 2, i_psc_mem_model.mode);
            rd(`PSC_REG_STATUS);
            chk("asleep", {!v[4], 1'b1}, r[3:2]);
            cmd(`PSC_CMD_WAKE);
            chk("awake", 0, i_psc_mem_model.mode);
        end
        v = 20'h00070 | 20'($urandom % 8);
        ahb(1'b1, `PSC_REG_CFG, {12'h0, v});
        cmd(`PSC_CMD_SW_WRITE);
        chk("sw write", {12'h0, v}, i_psc_mem_model.cr);
        chk("sw subset", 1, i_psc_mem_model.mode);
        rd(`PSC_REG_STATUS);
        chk("sw flag", 1, r[4]);
        chk("early", 0, i_psc_mem_model.early);
        rd(`PSC_REG_CTRL);
        chk("ctrl", {29'h0, `PSC_CMD_SW_WRITE}, r);
        ahb(1'b1, 32'h14, 32'h0);
        rd(32'h10);
        chk("unmapped", 32'h0, r);
        rd(`PSC_REG_CFG);
        chk("cfg kept", {12'h0, v}, r);
        report_and_stop;
    end
endmodule // tb
`default_nettype wire
